// ---- design/hold_timer.sv ----
// Hold timer that delays gain increase after the signal drops below target
`timescale 1ns/100ps
module hold_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic below_i,
  input wire logic tick_i,
  input wire logic [3:0] sel_i,
  output logic holding_o,
  output logic expired_o
);
  typedef enum logic [1:0] {IDLE, HOLDING, EXPIRED} hold_state_type;
  hold_state_type state_reg, state_next;
  logic [19:0] cnt_reg, cnt_next;
  logic [19:0] target;
  logic [3:0] sel_c;

  // Codes above the top value behave as the top value
  always_comb begin
    sel_c = (sel_i > level_ctl_pkg::HOLD_MAX_SEL) ?
      level_ctl_pkg::HOLD_MAX_SEL : sel_i;
    target = (sel_c == 4'h0) ? 20'h00000 :
      20'(level_ctl_pkg::HOLD_UNIT_SAMPLES) << (sel_c - 4'h1);
  end

  // Next state of the hold sequence
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (!run_i || !below_i) begin
      state_next = IDLE;
      cnt_next = 20'h00000;
    end else begin
      case (state_reg)
        IDLE: begin
          cnt_next = 20'h00000;
          state_next = (target == 20'h00000) ? EXPIRED : HOLDING;
        end
        HOLDING: begin
          if (tick_i) begin
            cnt_next = cnt_reg + 20'h00001;
          end
          if (cnt_reg >= target) begin
            state_next = EXPIRED;
          end
        end
        default: state_next = EXPIRED;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= IDLE;
      cnt_reg <= 20'h00000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign holding_o = (state_reg != EXPIRED);
  assign expired_o = (state_reg == EXPIRED);
endmodule

// ---- design/level_ctl.sv ----
// Hold, peak limiter and noise gate around the PGA gain, Wishbone registers
//
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
module level_ctl #(
  parameter int FAST_ATK_CYCLES = level_ctl_pkg::FAST_ATK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sample_tick_i,
  input wire logic below_target_i,
  input wire logic peak_over_i,
  input wire logic [7:0] level_atten_db_i,
  input wire logic [5:0] mic_boost_db_i,
  input wire logic attack_req_i,
  input wire logic decay_req_i,
  input wire logic [5:0] start_gain_i,
  output logic [5:0] pga_gain_o,
  output logic gate_active_o,
  output logic limiter_active_o,
  output logic hold_active_o
);
  // Configuration and status state
  logic en_reg, en_next;
  logic mode_reg, mode_next;
  logic [2:0] ceil_reg, ceil_next;
  logic [2:0] floor_reg, floor_next;
  logic [3:0] hold_reg, hold_next;
  logic [3:0] atk_reg, atk_next;
  logic gate_en_reg, gate_en_next;
  logic [2:0] gate_th_reg, gate_th_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [5:0] gain_reg, gain_next;
  logic gate_reg, gate_next;
  logic lim_reg, lim_next;
  logic [16:0] atk_cnt_reg, atk_cnt_next;
  logic holding, expired, normal_run;
  logic hold_act_next;
  logic [5:0] ceil_code, floor_code;
  logic signed [11:0] gate_rhs, gate_lhs;
  logic decay_ok, lim_tick, req;
  logic [5:0] idx;

  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  // Ceiling code 7+8n gives 35.25dB at 111; floor 8n gives -12dB at 000
  assign ceil_code = {ceil_reg, 3'h7};
  assign floor_code = {floor_reg, 3'h0};
  // Hold and gate only matter while running in normal mode
  assign normal_run = en_reg && !mode_reg;

  hold_timer hold_timer_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(normal_run),
    .below_i(below_target_i),
    .tick_i(sample_tick_i),
    .sel_i(hold_reg),
    .holding_o(holding),
    .expired_o(expired)
  );

  // Register writes; byte lanes 0 and 1 carry the nine-bit fields
  always_comb begin
    en_next = en_reg;
    mode_next = mode_reg;
    ceil_next = ceil_reg;
    floor_next = floor_reg;
    hold_next = hold_reg;
    atk_next = atk_reg;
    gate_en_next = gate_en_reg;
    gate_th_next = gate_th_reg;
    if (req && wb_we_i) begin
      if (idx == level_ctl_pkg::IDX_LEVEL_CONFIG) begin
        if (wb_sel_i[1]) begin
          en_next = wb_dat_i[level_ctl_pkg::LEVEL_EN_BIT];
        end
        if (wb_sel_i[0]) begin
          ceil_next = wb_dat_i[level_ctl_pkg::CEIL_LSB +: 3];
          floor_next = wb_dat_i[level_ctl_pkg::FLOOR_LSB +: 3];
        end
      end else if (idx == level_ctl_pkg::IDX_HOLD_CONFIG) begin
        if (wb_sel_i[0]) begin
          hold_next = wb_dat_i[level_ctl_pkg::HOLD_LSB +: 4];
        end
      end else if (idx == level_ctl_pkg::IDX_RATE_CONFIG) begin
        if (wb_sel_i[1]) begin
          mode_next = wb_dat_i[level_ctl_pkg::MODE_BIT];
        end
        if (wb_sel_i[0]) begin
          atk_next = wb_dat_i[level_ctl_pkg::ATK_LSB +: 4];
        end
      end else if (idx == level_ctl_pkg::IDX_GATE_CONFIG) begin
        if (wb_sel_i[0]) begin
          gate_en_next = wb_dat_i[level_ctl_pkg::GATE_EN_BIT];
          gate_th_next = wb_dat_i[level_ctl_pkg::GATE_TH_LSB +: 3];
        end
      end
    end
  end

  // Read data and ack; unmapped words read zero and still ack
  always_comb begin
    ack_next = req;
    rdata_next = 32'h00000000;
    if (req && !wb_we_i) begin
      if (idx == level_ctl_pkg::IDX_LEVEL_CONFIG) begin
        rdata_next[level_ctl_pkg::LEVEL_EN_BIT] = en_reg;
        rdata_next[level_ctl_pkg::CEIL_LSB +: 3] = ceil_reg;
        rdata_next[level_ctl_pkg::FLOOR_LSB +: 3] = floor_reg;
      end else if (idx == level_ctl_pkg::IDX_HOLD_CONFIG) begin
        rdata_next[level_ctl_pkg::HOLD_LSB +: 4] = hold_reg;
      end else if (idx == level_ctl_pkg::IDX_RATE_CONFIG) begin
        rdata_next[level_ctl_pkg::MODE_BIT] = mode_reg;
        rdata_next[level_ctl_pkg::ATK_LSB +: 4] = atk_reg;
      end else if (idx == level_ctl_pkg::IDX_GATE_CONFIG) begin
        rdata_next[level_ctl_pkg::GATE_EN_BIT] = gate_en_reg;
        rdata_next[level_ctl_pkg::GATE_TH_LSB +: 3] = gate_th_reg;
      end else if (idx == level_ctl_pkg::IDX_STATUS) begin
        rdata_next[level_ctl_pkg::ST_GATE_BIT] = gate_reg;
        rdata_next[level_ctl_pkg::ST_LIM_BIT] = lim_reg;
        rdata_next[level_ctl_pkg::ST_HOLD_BIT] = holding && normal_run;
        rdata_next[5:0] = gain_reg;
      end
    end
  end

  // Gate compare in quarter dB: -atten < -(39+6n) + gain + boost
  always_comb begin
    gate_lhs = -($signed({4'h0, level_atten_db_i}) * 12'sd4);
    gate_rhs = 12'(level_ctl_pkg::GAIN_QDB_OFFSET)
      + $signed({6'h00, gain_reg}) * 12'(level_ctl_pkg::GAIN_QDB_STEP)
      + $signed({6'h00, mic_boost_db_i}) * 12'sd4
      - (12'(level_ctl_pkg::GATE_BASE_DB)
      + $signed({9'h000, gate_th_reg})
      * 12'(level_ctl_pkg::GATE_STEP_DB)) * 12'sd4;
    gate_next = normal_run && gate_en_reg
      && (gate_lhs < gate_rhs);
  end

  // Fast attack pacing runs only while the input is over the limit
  always_comb begin
    lim_tick = 1'b0;
    atk_cnt_next = 17'h00000;
    if (en_reg && peak_over_i) begin
      if (atk_cnt_reg >= 17'(FAST_ATK_CYCLES - 1)) begin
        lim_tick = 1'b1;
      end else begin
        atk_cnt_next = atk_cnt_reg + 17'h00001;
      end
    end
    lim_next = en_reg && peak_over_i;
  end

  // Decay needs an expired hold and an open gate in normal mode
  assign decay_ok = mode_reg || (expired && !gate_reg);

  // Hold flag only while running below target in normal mode
  assign hold_act_next = holding && normal_run && below_target_i;

  // Gain steering; range clamp first, then limiter, then attack, then decay
  always_comb begin
    gain_next = gain_reg;
    if (!en_reg) begin
      gain_next = start_gain_i;
    end else if (gain_reg > ceil_code) begin
      gain_next = ceil_code;
    end else if (gain_reg < floor_code) begin
      gain_next = floor_code;
    end else if (peak_over_i) begin
      if (lim_tick && gain_reg > floor_code) begin
        gain_next = gain_reg - 6'h01;
      end
    end else if (attack_req_i) begin
      if (gain_reg > floor_code) begin
        gain_next = gain_reg - 6'h01;
      end
    end else if (decay_req_i && decay_ok) begin
      if (gain_reg < ceil_code) begin
        gain_next = gain_reg + 6'h01;
      end
    end
  end

  // All state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= 1'b0;
      mode_reg <= 1'b0;
      ceil_reg <= level_ctl_pkg::CEIL_RESET;
      floor_reg <= level_ctl_pkg::FLOOR_RESET;
      hold_reg <= level_ctl_pkg::HOLD_RESET;
      atk_reg <= level_ctl_pkg::ATK_RESET;
      gate_en_reg <= 1'b0;
      gate_th_reg <= level_ctl_pkg::GATE_TH_RESET;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      gain_reg <= level_ctl_pkg::GAIN_RESET;
      gate_reg <= 1'b0;
      lim_reg <= 1'b0;
      atk_cnt_reg <= 17'h00000;
      hold_active_o <= 1'b0;
    end else begin
      en_reg <= en_next;
      mode_reg <= mode_next;
      ceil_reg <= ceil_next;
      floor_reg <= floor_next;
      hold_reg <= hold_next;
      atk_reg <= atk_next;
      gate_en_reg <= gate_en_next;
      gate_th_reg <= gate_th_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      gain_reg <= gain_next;
      gate_reg <= gate_next;
      lim_reg <= lim_next;
      atk_cnt_reg <= atk_cnt_next;
      hold_active_o <= hold_act_next;
    end
  end

  // Outputs straight from flops
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign pga_gain_o = gain_reg;
  assign gate_active_o = gate_reg;
  assign limiter_active_o = lim_reg;

  // Checks
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_gain_to_ceiling: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_reg && gain_reg > ceil_code) |=> gain_reg == $past(ceil_code))
    else $error("gain not pulled to ceiling");
  a_gain_to_floor: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_reg && gain_reg < floor_code) |=> gain_reg == $past(floor_code))
    else $error("gain not pulled to floor");
  a_gate_no_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_reg && gate_reg && !mode_reg && gain_reg >= floor_code)
    |=> gain_reg <= $past(gain_reg))
    else $error("gain rose while gated");
  a_limiter_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (lim_tick && gain_reg > floor_code && gain_reg <= ceil_code)
    |=> gain_reg == $past(gain_reg) - 6'h01)
    else $error("limiter did not step gain down");
  a_limiter_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_reg && peak_over_i && gain_reg >= floor_code)
    |=> gain_reg <= $past(gain_reg))
    else $error("gain rose above clip limit");
  a_hold_no_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    (normal_run && holding && gain_reg >= floor_code
    && gain_reg <= ceil_code) |=> gain_reg <= $past(gain_reg))
    else $error("gain rose during hold");
  a_gate_mode_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_reg || !gate_en_reg) |=> !gate_reg)
    else $error("gate active in limiter mode or disabled");
  a_hold_cancel: assert property (@(posedge clk_i) disable iff (rst_i)
    !below_target_i |=> !hold_active_o)
    else $error("hold not cancelled");
  c_limiter: cover property (@(posedge clk_i) lim_tick);
  c_gate: cover property (@(posedge clk_i) gate_reg);
  c_hold_expire: cover property (@(posedge clk_i) normal_run && expired
    && decay_req_i);
endmodule

// ---- design/level_ctl_pkg.sv ----
// Constants for the level control hold, peak limiter and noise gate block
// Notes on behaviour
// - In normal mode, wait the hold period before gain may rise again.
// - Four-bit hold select: 0 no delay, 1 is 2.67ms, doubling to 1.37s.
// - Hold expiry means a new average level; gain may then rise.
// - Signal above threshold during hold cancels the hold.
// - Input over 87.5% full scale ramps gain down at fastest attack rate.
// - Peak limiter runs whenever level control runs; no own enable.
// - Gate engages when level is below threshold plus PGA and boost gain.
// - While gated, gain is held and never ramps upward; code blocks only decay, attack and limiter steps still lower it.
// - Three-bit gate threshold: -39dB at 0, 6dB lower per step.
// - Gate enable bit, reset 0, switches the noise gate on and off.
// - Gate acts only in normal mode, never in limiter mode.
// - While enabled, gain stays between ceiling and floor; else no limit.
// - Gain outside the range is moved back into range at once.
// - Mode bit: 0 normal, 1 limiter; hold and gate only in normal.
package level_ctl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_LEVEL_CONFIG = 6'h20;
  localparam logic [5:0] IDX_HOLD_CONFIG = 6'h21;
  localparam logic [5:0] IDX_RATE_CONFIG = 6'h22;
  localparam logic [5:0] IDX_GATE_CONFIG = 6'h23;
  localparam logic [5:0] IDX_STATUS = 6'h24;
  // Field positions
  localparam int LEVEL_EN_BIT = 8;
  localparam int CEIL_LSB = 3;
  localparam int FLOOR_LSB = 0;
  localparam int HOLD_LSB = 4;
  localparam int MODE_BIT = 8;
  localparam int ATK_LSB = 0;
  localparam int GATE_EN_BIT = 3;
  localparam int GATE_TH_LSB = 0;
  localparam int ST_GATE_BIT = 8;
  localparam int ST_LIM_BIT = 7;
  localparam int ST_HOLD_BIT = 6;
  // Reset values
  localparam logic [2:0] CEIL_RESET = 3'h7;
  localparam logic [2:0] FLOOR_RESET = 3'h0;
  localparam logic [3:0] HOLD_RESET = 4'h0;
  localparam logic [3:0] ATK_RESET = 4'h0;
  localparam logic [2:0] GATE_TH_RESET = 3'h0;
  localparam logic [5:0] GAIN_RESET = 6'h10;
  // Hold: 2.67ms is 128 samples at 48 kHz; largest code is 1010
  localparam int HOLD_UNIT_SAMPLES = 128;
  localparam logic [3:0] HOLD_MAX_SEL = 4'ha;
  // Fastest attack step, 104 us, at 250 MHz
  localparam int CLK_PERIOD_NS = 4;
  localparam int FAST_ATK_NS = 104000;
  localparam int FAST_ATK_CYCLES = FAST_ATK_NS / CLK_PERIOD_NS;
  // Gain code is 0.75dB per step from -12dB; 6dB spans 8 codes
  localparam int GAIN_QDB_OFFSET = -48;
  localparam int GAIN_QDB_STEP = 3;
  localparam int GATE_BASE_DB = 39;
  localparam int GATE_STEP_DB = 6;
endpackage

// ---- dv/level_ctl_test.sv ----
// Self-checking bench for the hold, peak limiter and noise gate block
`timescale 1ns/100ps
module level_ctl_test;
  // Short limiter pacing keeps the run brief
  localparam int ATK = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic sample_tick_i = 1'b0;
  logic below_target_i = 1'b0;
  logic peak_over_i = 1'b0;
  logic [7:0] level_atten_db_i = 8'h0;
  logic [5:0] mic_boost_db_i = 6'h0;
  logic attack_req_i = 1'b0;
  logic decay_req_i = 1'b0;
  logic [5:0] start_gain_i = 6'h10;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [5:0] pga_gain_o;
  logic gate_active_o;
  logic limiter_active_o;
  logic hold_active_o;
  int bad_count = 0;
  int tests_run = 0;
  logic [31:0] rd;

  always #2 clk_i = ~clk_i;

  level_ctl #(.FAST_ATK_CYCLES(ATK)) level_ctl_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_tick_i(sample_tick_i), .below_target_i(below_target_i),
    .peak_over_i(peak_over_i), .level_atten_db_i(level_atten_db_i),
    .mic_boost_db_i(mic_boost_db_i), .attack_req_i(attack_req_i),
    .decay_req_i(decay_req_i), .start_gain_i(start_gain_i),
    .pga_gain_o(pga_gain_o), .gate_active_o(gate_active_o),
    .limiter_active_o(limiter_active_o), .hold_active_o(hold_active_o)
  );

  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request stands until ack is sampled high at a rising edge
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    n = 0;
    rdat = 32'h0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      wrap_up();
    end else begin
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    wb(1'b1, adr, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, rd);
    chk(rd, exp);
  endtask

  // Ends mid-cycle so outputs are settled
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      sample_tick_i <= 1'b1;
      @(posedge clk_i);
      sample_tick_i <= 1'b0;
    end
  endtask

  task automatic pulse(input logic up, input logic [5:0] exp);
    @(posedge clk_i);
    if (up) decay_req_i <= 1'b1;
    else attack_req_i <= 1'b1;
    @(posedge clk_i);
    decay_req_i <= 1'b0;
    attack_req_i <= 1'b0;
    step(2);
    chk(pga_gain_o, exp);
  endtask

  // Disabled load of the start gain, then enable with the given config
  task automatic arm(input logic [5:0] sg, input logic [8:0] cfg);
    @(posedge clk_i);
    start_gain_i <= sg;
    wr(8'h80, {23'h0, 1'b0, cfg[7:0]});
    wr(8'h80, {23'h0, cfg});
    step(3);
  endtask

  task automatic t_regs();
    rdchk(8'h80, 32'h38);
    rdchk(8'h84, 32'h0);
    rdchk(8'h8c, 32'h0);
    rdchk(8'h90, 32'h10);
    wr(8'h84, 32'ha0);
    rdchk(8'h84, 32'ha0);
    wr(8'h8c, 32'hf);
    rdchk(8'h8c, 32'hf);
    wr(8'h88, 32'h10a);
    rdchk(8'h88, 32'h10a);
    wr(8'h88, 32'h0);
    wr(8'hfc, 32'h1ff);
    rdchk(8'hfc, 32'h0);
    wr(8'h84, 32'h0);
    wr(8'h8c, 32'h0);
  endtask

  task automatic t_clamp();
    wr(8'h80, 32'h10);
    @(posedge clk_i);
    start_gain_i <= 6'h30;
    below_target_i <= 1'b1;
    step(3);
    chk(pga_gain_o, 6'h30);
    wr(8'h80, 32'h110);
    step(3);
    chk(pga_gain_o, 6'h17);
    pulse(1'b1, 6'h17);
    arm(6'h02, 9'h111);
    chk(pga_gain_o, 6'h08);
    pulse(1'b0, 6'h08);
  endtask

  // Limiter steps through a running hold, at the fast pace whatever attack
  task automatic t_limiter();
    wr(8'h84, 32'h10);
    arm(6'h10, 9'h138);
    wr(8'h88, 32'ha);
    @(posedge clk_i);
    peak_over_i <= 1'b1;
    repeat (11) @(posedge clk_i);
    @(negedge clk_i);
    chk(pga_gain_o, 6'h0e);
    chk(limiter_active_o, 1'b1);
    @(posedge clk_i);
    peak_over_i <= 1'b0;
    step(3);
    chk(limiter_active_o, 1'b0);
    // Twelve edges over the limit give three paced steps
    chk(pga_gain_o, 6'h0d);
    wr(8'h80, 32'h38);
    @(posedge clk_i);
    peak_over_i <= 1'b1;
    step(12);
    chk(limiter_active_o, 1'b0);
    chk(pga_gain_o, 6'h10);
    @(posedge clk_i);
    peak_over_i <= 1'b0;
    wr(8'h88, 32'h0);
  endtask

  // Code 1 holds 128 ticks; restart and cancel are both exercised
  task automatic t_hold();
    @(posedge clk_i);
    below_target_i <= 1'b0;
    arm(6'h10, 9'h138);
    @(posedge clk_i);
    below_target_i <= 1'b1;
    step(3);
    chk(hold_active_o, 1'b1);
    pulse(1'b1, 6'h10);
    ticks(127);
    step(1);
    chk(hold_active_o, 1'b1);
    ticks(1);
    step(2);
    chk(hold_active_o, 1'b0);
    pulse(1'b1, 6'h11);
    @(posedge clk_i);
    below_target_i <= 1'b0;
    step(2);
    @(posedge clk_i);
    below_target_i <= 1'b1;
    ticks(60);
    @(posedge clk_i);
    below_target_i <= 1'b0;
    step(2);
    chk(hold_active_o, 1'b0);
    // Above target a decay request is refused
    pulse(1'b1, 6'h11);
    @(posedge clk_i);
    below_target_i <= 1'b1;
    ticks(100);
    step(1);
    chk(hold_active_o, 1'b1);
    wr(8'h88, 32'h100);
    step(2);
    chk(hold_active_o, 1'b0);
    pulse(1'b1, 6'h12);
    wr(8'h88, 32'h0);
    wr(8'h84, 32'h0);
  endtask

  // Fields: enable, mode, threshold, boost, attenuation, expected gate
  // Thresholds stay off both ends of the range
  task automatic t_gate();
    logic [19:0] row [7];
    logic [5:0] g;
    row = '{
      {1'b1, 1'b0, 3'h1, 6'h00, 8'h3c, 1'b1},
      {1'b1, 1'b0, 3'h6, 6'h00, 8'h3c, 1'b0},
      {1'b1, 1'b0, 3'h6, 6'h00, 8'h5a, 1'b1},
      {1'b1, 1'b0, 3'h1, 6'h14, 8'h1e, 1'b1},
      {1'b1, 1'b0, 3'h1, 6'h00, 8'h1e, 1'b0},
      {1'b1, 1'b1, 3'h1, 6'h00, 8'h3c, 1'b0},
      {1'b0, 1'b0, 3'h1, 6'h00, 8'h3c, 1'b0}
    };
    g = 6'h10;
    arm(6'h10, 9'h138);
    for (int i = 0; i < 7; i++) begin
      wr(8'h88, {23'h0, row[i][18], 8'h0});
      wr(8'h8c, {28'h0, row[i][19], row[i][17:15]});
      @(posedge clk_i);
      mic_boost_db_i <= row[i][14:9];
      level_atten_db_i <= row[i][8:1];
      step(3);
      chk(gate_active_o, row[i][0]);
      if (row[i][0] !== 1'b1) g = g + 6'h1;
      pulse(1'b1, g);
    end
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_clamp();
    t_limiter();
    t_hold();
    t_gate();
    wrap_up();
  end
endmodule
